// *** frame_fifo.sv ***
`timescale 1ns/100ps
module frame_fifo
#(
	parameter int WIDTH = 9,
	parameter int DEPTH = 32
)
(
	input  wire logic             i_sys_clk,
	input  wire logic             i_resetn,
	input  wire logic             i_in_valid,
	output logic                  o_in_ready,
	input  wire logic [WIDTH-1:0] i_in_data,
	output logic                  o_out_valid,
	input  wire logic             i_out_ready,
	output logic      [WIDTH-1:0] o_out_data
);

	localparam int AW = $clog2(DEPTH);

	typedef struct packed
	{
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [AW-1:0]               wr_ptr;
		logic [AW-1:0]               rd_ptr;
		logic [AW:0]                 count;
	} fifo_state_t;

	fifo_state_t st;
	fifo_state_t next_st;
	logic        push;
	logic        pop;

	assign o_in_ready  = (st.count != DEPTH[AW:0]);
	assign o_out_valid = (st.count != '0);
	assign o_out_data  = st.mem[st.rd_ptr];
	assign push        = i_in_valid && o_in_ready;
	assign pop         = o_out_valid && i_out_ready;

	always_comb
	begin
		next_st = st;
		if (push)
		begin
			next_st.mem[st.wr_ptr] = i_in_data;
			next_st.wr_ptr         = st.wr_ptr + 1'b1;
		end
		if (pop)
			next_st.rd_ptr = st.rd_ptr + 1'b1;
		if (push && !pop)
			next_st.count = st.count + 1'b1;
		else if (pop && !push)
			next_st.count = st.count - 1'b1;
	end

	always_ff @(posedge i_sys_clk or negedge i_resetn)
	begin
		if (!i_resetn)
			st <= '0;
		else
			st <= next_st;
	end

endmodule : frame_fifo

// *** gw_cfg_expect.svh ***
function automatic logic [19:0] exp_rate(input logic [15:0] code);
	logic [19:0] tbl [7];
	tbl = '{20'h00960, 20'h012C0, 20'h02580, 20'h04B00, 20'h09600, 20'h0E100, 20'h1C200};
	exp_rate = (code < 16'h0007) ? tbl[code[2:0]] : {4'h0, code} * 20'h0000A;
endfunction : exp_rate

// *** gw_cfg_pkg.sv ***
package gw_cfg_pkg;

	// Register indices on the Modbus register space
	localparam logic [7:0]  REG_VERSION     = 8'h00;
	localparam logic [7:0]  REG_SLAVE_ADDR  = 8'h01;
	localparam logic [7:0]  REG_SPEED       = 8'h02;
	localparam logic [7:0]  REG_WORD_FMT    = 8'h03;
	localparam logic [7:0]  REG_PARITY      = 8'h04;
	localparam logic [7:0]  REG_FRAMING     = 8'h06;
	localparam logic [7:0]  REG_WATCHDOG    = 8'h08;
	localparam logic [7:0]  REG_DFLT_OUT    = 8'h0C;
	localparam logic [7:0]  REG_OP_MODE     = 8'h0D;
	localparam logic [7:0]  REG_RATE_SLOW   = 8'h0E;
	localparam logic [7:0]  REG_RATE_NORM   = 8'h0F;
	localparam logic [7:0]  REG_RATE_FAST   = 8'h10;
	localparam logic [7:0]  REG_INPUTS      = 8'h32;
	localparam logic [7:0]  REG_OUTPUTS     = 8'h33;

	// Word format fields
	localparam int          STOP_LSB        = 0;
	localparam int          DATA_LSB        = 8;

	// Default values
	localparam logic [15:0] DEF_SPEED       = 16'h0003;
	localparam logic [15:0] DEF_WORD_FMT    = 16'h0801;
	localparam logic [15:0] DEF_PARITY      = 16'h0000;
	localparam logic [15:0] DEF_FRAMING     = 16'h0000;
	localparam logic [15:0] DEF_WATCHDOG    = 16'h0000;
	localparam logic [15:0] DEF_DFLT_OUT    = 16'h0000;
	localparam logic [15:0] DEF_OUTPUTS     = 16'h0000;
	localparam logic [15:0] DEF_OP_MODE     = 16'h0001;
	localparam logic [15:0] DEF_RATE_SLOW   = 16'h2710;
	localparam logic [15:0] DEF_RATE_NORM   = 16'h07D0;
	localparam logic [15:0] DEF_RATE_FAST   = 16'h01F4;
	localparam logic [15:0] DEF_RESP_TMO    = 16'h01F4;
	localparam logic [7:0]  DEF_SLAVE_ADDR  = 8'h01;

	// Parity and framing codes
	localparam logic [2:0]  PAR_NONE        = 3'h0;
	localparam logic [2:0]  PAR_ODD         = 3'h1;
	localparam logic [2:0]  PAR_EVEN        = 3'h2;
	localparam logic [2:0]  PAR_MARK        = 3'h3;
	localparam logic [2:0]  PAR_SPACE       = 3'h4;
	localparam logic [15:0] FRAME_ASCII     = 16'h0001;

	// Timing
	localparam int          CLK_HZ          = 40000000;
	localparam int          MS_PER_S        = 1000;
	localparam int          CYCLES_PER_MS   = CLK_HZ / MS_PER_S;
	localparam int          FLASH_MS        = 250;
	localparam int          COMM_LED_MS     = 50;

	// Frame FIFO
	localparam int          FIFO_WIDTH      = 9;
	localparam int          FIFO_DEPTH      = 32;

	localparam int          NUM_INPUTS      = 4;
	localparam int          NUM_RELAYS      = 3;

endpackage : gw_cfg_pkg

// *** gw_cfg_watchdog_sva.sv ***
`timescale 1ns/100ps
module gw_cfg_watchdog_sva
	import gw_cfg_pkg::*;
(
	input wire logic i_sys_clk,
	input wire logic i_resetn,
	input wire logic i_reg_wr,
	input wire logic i_reg_rd,
	input wire logic [7:0] i_reg_addr,
	input wire logic o_reg_ack,
	input wire logic [15:0] o_reg_rdata,
	input wire logic [gw_cfg_pkg::NUM_INPUTS-1:0] i_dig_in,
	input wire logic [gw_cfg_pkg::NUM_INPUTS-1:0] o_input_led,
	input wire logic o_nv_store,
	input wire logic [7:0] o_slave_addr,
	input wire logic [19:0] o_baud_rate,
	input wire logic [2:0] o_parity_mode,
	input wire logic o_two_stop_bits,
	input wire logic o_seven_data_bits,
	input wire logic o_ascii_mode
);
	`include "gw_cfg_expect.svh"
	default clocking cb @(posedge i_sys_clk);
	endclocking
	default disable iff (!i_resetn);
	////////////////////////////////////////
	sequence req_s;
		i_reg_rd || i_reg_wr;
	endsequence
	sequence rd_s(logic [7:0] a);
		i_reg_rd && (i_reg_addr == a);
	endsequence
	sequence in_settled_s;
		$stable(i_dig_in) [*3];
	endsequence
	////////////////////////////////////////
	a_ack_after_req: assert property (req_s |=> o_reg_ack)
		else $error("no acknowledge after request");
	a_ack_no_req: assert property (!(i_reg_rd || i_reg_wr) |=> !o_reg_ack)
		else $error("acknowledge without request");
	a_speed_decode: assert property (rd_s(REG_SPEED) |=> o_baud_rate == exp_rate(o_reg_rdata))
		else $error("baud rate does not match speed code");
	a_parity_decode: assert property (rd_s(REG_PARITY) |=>
		o_parity_mode == ((o_reg_rdata <= 16'h0004) ? o_reg_rdata[2:0] : 3'h0))
		else $error("parity mode does not match code");
	a_word_format: assert property (rd_s(REG_WORD_FMT) |=>
		(o_two_stop_bits == (o_reg_rdata[7:0] == 8'h02)) && (o_seven_data_bits == (o_reg_rdata[15:8] == 8'h07)))
		else $error("stop or data bits wrong");
	a_framing_mode: assert property (rd_s(REG_FRAMING) |=> o_ascii_mode == (o_reg_rdata == 16'h0001))
		else $error("framing mode wrong");
	a_input_led_sync: assert property (in_settled_s |-> o_input_led == i_dig_in)
		else $error("input indicator does not follow input");
	a_restore_values: assert property (o_nv_store |->
		((o_slave_addr == 8'h01) && (o_baud_rate == 20'h04B00)) ##1 !o_nv_store)
		else $error("restore values or store pulse wrong");
endmodule : gw_cfg_watchdog_sva

bind gw_config_watchdog gw_cfg_watchdog_sva i_sva
(
	.i_sys_clk, .i_resetn, .i_reg_wr, .i_reg_rd, .i_reg_addr, .o_reg_ack, .o_reg_rdata, .i_dig_in,
	.o_input_led, .o_nv_store, .o_slave_addr, .o_baud_rate, .o_parity_mode, .o_two_stop_bits,
	.o_seven_data_bits, .o_ascii_mode
);

// *** gw_config_watchdog.sv ***
`timescale 1ns/100ps
module gw_config_watchdog
	import gw_cfg_pkg::*;
#(
	parameter int          TICK_CYCLES = gw_cfg_pkg::CYCLES_PER_MS,
	parameter logic [15:0] VERSION_ID  = 16'h0A01 // Arbitrary value
)
(
	input  wire logic                              i_sys_clk,
	input  wire logic                              i_resetn,
	input  wire logic                              i_reg_wr,
	input  wire logic                              i_reg_rd,
	input  wire logic [7:0]                        i_reg_addr,
	input  wire logic [15:0]                       i_reg_wdata,
	output logic                                   o_reg_ack,
	output logic      [15:0]                       o_reg_rdata,
	input  wire logic                              i_frm_valid,
	output logic                                   o_frm_ready,
	input  wire logic [7:0]                        i_frm_data,
	input  wire logic                              i_frm_first,
	input  wire logic                              i_frm_last,
	output logic                                   o_ser_valid,
	input  wire logic                              i_ser_ready,
	output logic      [7:0]                        o_ser_data,
	output logic                                   o_ser_last,
	input  wire logic                              i_ser_sent,
	input  wire logic                              i_msg_valid,
	input  wire logic                              i_defaults_restore_switch,
	input  wire logic [gw_cfg_pkg::NUM_INPUTS-1:0] i_dig_in,
	input  wire logic [7:0]                        i_nv_slave_addr,
	output logic                                   o_nv_store,
	output logic      [7:0]                        o_slave_addr,
	output logic      [19:0]                       o_baud_rate,
	output logic      [2:0]                        o_parity_mode,
	output logic                                   o_two_stop_bits,
	output logic                                   o_seven_data_bits,
	output logic                                   o_ascii_mode,
	output logic                                   o_gateway_mode,
	output logic      [15:0]                       o_resp_timeout_ms,
	output logic      [15:0]                       o_rate_slow_ms,
	output logic      [15:0]                       o_rate_norm_ms,
	output logic      [15:0]                       o_rate_fast_ms,
	output logic      [gw_cfg_pkg::NUM_RELAYS-1:0] o_relay,
	output logic      [gw_cfg_pkg::NUM_RELAYS-1:0] o_relay_led,
	output logic      [gw_cfg_pkg::NUM_INPUTS-1:0] o_input_led,
	output logic                                   o_power_led,
	output logic                                   o_comm_led
);

	import gw_cfg_pkg::*;

	////////////////////////////////////////////////////////////////////////////////
	// State

	typedef enum logic [1:0]
	{
		BOOT,
		RESTORING,
		RUNNING
	} phase_t;

	typedef struct packed
	{
		phase_t                phase;
		logic [1:0]            boot_cnt;
		logic                  sw_s1;
		logic                  sw_s2;
		logic [NUM_INPUTS-1:0] in_s1;
		logic [NUM_INPUTS-1:0] in_s2;
		logic [15:0]           div_cnt;
		logic                  tick;
		logic [15:0]           flash_cnt;
		logic                  flash;
		logic [15:0]           speed;
		logic [15:0]           word_fmt;
		logic [15:0]           parity;
		logic [15:0]           framing;
		logic [15:0]           watchdog;
		logic [15:0]           dflt_out;
		logic [15:0]           op_mode;
		logic [15:0]           rate_slow;
		logic [15:0]           rate_norm;
		logic [15:0]           rate_fast;
		logic [15:0]           resp_tmo;
		logic [15:0]           outputs;
		logic [7:0]            slave_addr;
		logic                  nv_store;
		logic                  fwd;
		logic                  ack;
		logic [15:0]           rdata;
	} gw_state_t;

	localparam logic [15:0] TICK_LAST  = 16'(TICK_CYCLES - 1);
	localparam logic [15:0] FLASH_LAST = 16'(FLASH_MS - 1);
	localparam logic [15:0] COMM_HOLD  = 16'(COMM_LED_MS);

	gw_state_t st;
	gw_state_t next_st;

	logic       fwd_now;
	logic       fifo_in_ready;
	logic       fifo_push;
	logic [8:0] fifo_out;
	logic       wd_load;
	logic       wd_expired;
	logic       comm_running;
	logic       wr_ok;

	////////////////////////////////////////////////////////////////////////////////
	// Defaults, applied at reset and on restore

	function automatic gw_state_t load_defaults(input gw_state_t s);
		gw_state_t r;
		r           = s;
		r.speed     = DEF_SPEED;
		r.word_fmt  = DEF_WORD_FMT;
		r.parity    = DEF_PARITY;
		r.framing   = DEF_FRAMING;
		r.op_mode   = DEF_OP_MODE;
		r.resp_tmo  = DEF_RESP_TMO;
		r.rate_slow = DEF_RATE_SLOW;
		r.rate_norm = DEF_RATE_NORM;
		r.rate_fast = DEF_RATE_FAST;
		r.watchdog  = DEF_WATCHDOG;
		r.dflt_out  = DEF_DFLT_OUT;
		r.outputs   = DEF_OUTPUTS;
		return r;
	endfunction : load_defaults

	////////////////////////////////////////////////////////////////////////////////
	// Frame routing by unit address

	assign fwd_now     = i_frm_first ? (i_frm_data != st.slave_addr) : st.fwd;
	assign o_frm_ready = (st.phase == RUNNING) && (fwd_now ? fifo_in_ready : 1'b1);
	assign fifo_push   = i_frm_valid && (st.phase == RUNNING) && fwd_now;

	frame_fifo #(
		.WIDTH (FIFO_WIDTH),
		.DEPTH (FIFO_DEPTH)
	) u_frame_fifo (
		.i_sys_clk   (i_sys_clk),
		.i_resetn    (i_resetn),
		.i_in_valid  (fifo_push),
		.o_in_ready  (fifo_in_ready),
		.i_in_data   ({i_frm_last, i_frm_data}),
		.o_out_valid (o_ser_valid),
		.i_out_ready (i_ser_ready),
		.o_out_data  (fifo_out)
	);

	assign o_ser_data = fifo_out[7:0];
	assign o_ser_last = fifo_out[8];

	////////////////////////////////////////////////////////////////////////////////
	// Output watchdog and communication indicator timers

	assign wr_ok   = i_reg_wr && (st.phase == RUNNING);
	assign wd_load = i_msg_valid || (wr_ok && (i_reg_addr == REG_WATCHDOG))
		|| (st.phase != RUNNING);

	ms_countdown u_watchdog (
		.i_sys_clk (i_sys_clk),
		.i_resetn  (i_resetn),
		.i_tick    (st.tick),
		.i_load    (wd_load),
		.i_value   (wr_ok && (i_reg_addr == REG_WATCHDOG) ? i_reg_wdata : st.watchdog),
		.o_running (),
		.o_expired (wd_expired)
	);

	ms_countdown u_comm_hold (
		.i_sys_clk (i_sys_clk),
		.i_resetn  (i_resetn),
		.i_tick    (st.tick),
		.i_load    (i_ser_sent),
		.i_value   (COMM_HOLD),
		.o_running (comm_running),
		.o_expired ()
	);

	////////////////////////////////////////////////////////////////////////////////
	// Next state

	always_comb
	begin
		next_st          = st;
		next_st.sw_s1    = i_defaults_restore_switch;
		next_st.sw_s2    = st.sw_s1;
		next_st.in_s1    = i_dig_in;
		next_st.in_s2    = st.in_s1;
		next_st.nv_store = 1'b0;
		next_st.ack      = 1'b0;
		next_st.tick     = 1'b0;

		// Millisecond tick
		if (st.div_cnt == TICK_LAST)
		begin
			next_st.div_cnt = 16'h0000;
			next_st.tick    = 1'b1;
		end
		else
			next_st.div_cnt = st.div_cnt + 16'h0001;

		unique case (st.phase)
			BOOT:
			begin
				next_st.boot_cnt = st.boot_cnt + 2'h1;
				if (st.boot_cnt == 2'h3)
				begin
					if (st.sw_s2)
					begin
						next_st            = load_defaults(next_st);
						next_st.slave_addr = DEF_SLAVE_ADDR;
						next_st.nv_store   = 1'b1;
						next_st.phase      = RESTORING;
					end
					else
					begin
						next_st.slave_addr = i_nv_slave_addr;
						next_st.phase      = RUNNING;
					end
				end
			end
			RESTORING:
			begin
				if (st.tick)
				begin
					if (st.flash_cnt == FLASH_LAST)
					begin
						next_st.flash_cnt = 16'h0000;
						next_st.flash     = ~st.flash;
					end
					else
						next_st.flash_cnt = st.flash_cnt + 16'h0001;
				end
				if (!st.sw_s2)
					next_st.phase = RUNNING;
			end
			RUNNING:
			begin
				if (i_frm_valid && o_frm_ready)
					next_st.fwd = fwd_now && !i_frm_last;

				if (i_reg_wr)
				begin
					unique case (i_reg_addr)
						REG_SPEED:     next_st.speed     = i_reg_wdata;
						REG_WORD_FMT:  next_st.word_fmt  = i_reg_wdata;
						REG_PARITY:    next_st.parity    = i_reg_wdata;
						REG_FRAMING:   next_st.framing   = i_reg_wdata;
						REG_WATCHDOG:  next_st.watchdog  = i_reg_wdata;
						REG_DFLT_OUT:  next_st.dflt_out  = i_reg_wdata;
						REG_OP_MODE:   next_st.op_mode   = i_reg_wdata;
						REG_RATE_SLOW: next_st.rate_slow = i_reg_wdata;
						REG_RATE_NORM: next_st.rate_norm = i_reg_wdata;
						REG_RATE_FAST: next_st.rate_fast = i_reg_wdata;
						REG_OUTPUTS:   next_st.outputs   = i_reg_wdata;
						default:       next_st.ack       = 1'b0;
					endcase
				end
			end
		endcase

		// Register reads; read-only spaces ignore writes
		if (i_reg_rd || i_reg_wr)
			next_st.ack = 1'b1;
		if (i_reg_rd)
		begin
			unique case (i_reg_addr)
				REG_VERSION:    next_st.rdata = VERSION_ID;
				REG_SLAVE_ADDR: next_st.rdata = {8'h00, st.slave_addr};
				REG_SPEED:      next_st.rdata = st.speed;
				REG_WORD_FMT:   next_st.rdata = st.word_fmt;
				REG_PARITY:     next_st.rdata = st.parity;
				REG_FRAMING:    next_st.rdata = st.framing;
				REG_WATCHDOG:   next_st.rdata = st.watchdog;
				REG_DFLT_OUT:   next_st.rdata = st.dflt_out;
				REG_OP_MODE:    next_st.rdata = st.op_mode;
				REG_RATE_SLOW:  next_st.rdata = st.rate_slow;
				REG_RATE_NORM:  next_st.rdata = st.rate_norm;
				REG_RATE_FAST:  next_st.rdata = st.rate_fast;
				REG_INPUTS:     next_st.rdata = {12'h000, st.in_s2};
				REG_OUTPUTS:    next_st.rdata = {13'h0000, o_relay};
				default:        next_st.rdata = 16'h0000;
			endcase
		end
	end

	always_ff @(posedge i_sys_clk or negedge i_resetn)
	begin
		if (!i_resetn)
		begin
			st            <= '0;
			st.phase      <= BOOT;
			st.speed      <= DEF_SPEED;
			st.word_fmt   <= DEF_WORD_FMT;
			st.parity     <= DEF_PARITY;
			st.framing    <= DEF_FRAMING;
			st.watchdog   <= DEF_WATCHDOG;
			st.op_mode    <= DEF_OP_MODE;
			st.rate_slow  <= DEF_RATE_SLOW;
			st.rate_norm  <= DEF_RATE_NORM;
			st.rate_fast  <= DEF_RATE_FAST;
			st.resp_tmo   <= DEF_RESP_TMO;
			st.slave_addr <= DEF_SLAVE_ADDR;
		end
		else
			st <= next_st;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Decoded configuration

	always_comb
	begin
		unique case (st.speed)
			16'h0000: o_baud_rate = 20'd2400;
			16'h0001: o_baud_rate = 20'd4800;
			16'h0002: o_baud_rate = 20'd9600;
			16'h0003: o_baud_rate = 20'd19200;
			16'h0004: o_baud_rate = 20'd38400;
			16'h0005: o_baud_rate = 20'd57600;
			16'h0006: o_baud_rate = 20'd115200;
			default:  o_baud_rate = {st.speed, 3'b000} + {3'b000, st.speed, 1'b0};
		endcase
	end

	assign o_parity_mode     = (st.parity > 16'h0004) ? PAR_NONE : st.parity[2:0];
	assign o_two_stop_bits   = (st.word_fmt[STOP_LSB +: 8] == 8'h02);
	assign o_seven_data_bits = (st.word_fmt[DATA_LSB +: 8] == 8'h07);
	assign o_ascii_mode      = (st.framing == FRAME_ASCII);
	assign o_gateway_mode    = st.op_mode[0];
	assign o_resp_timeout_ms = st.resp_tmo;
	assign o_rate_slow_ms    = st.rate_slow;
	assign o_rate_norm_ms    = st.rate_norm;
	assign o_rate_fast_ms    = st.rate_fast;
	assign o_slave_addr      = st.slave_addr;
	assign o_nv_store        = st.nv_store;
	assign o_reg_ack         = st.ack;
	assign o_reg_rdata       = st.rdata;

	////////////////////////////////////////////////////////////////////////////////
	// Relays and indicators

	assign o_relay     = wd_expired ? st.dflt_out[NUM_RELAYS-1:0] : st.outputs[NUM_RELAYS-1:0];
	assign o_relay_led = o_relay;
	assign o_input_led = st.in_s2;
	assign o_power_led = (st.phase == RESTORING) ? st.flash : 1'b1;
	assign o_comm_led  = (st.phase == RESTORING) ? st.flash : comm_running;

endmodule : gw_config_watchdog

// *** ms_countdown.sv ***
`timescale 1ns/100ps
module ms_countdown
(
	input  wire logic        i_sys_clk,
	input  wire logic        i_resetn,
	input  wire logic        i_tick,
	input  wire logic        i_load,
	input  wire logic [15:0] i_value,
	output logic             o_running,
	output logic             o_expired
);

	typedef struct packed
	{
		logic [15:0] cnt;
		logic        armed;
	} cd_state_t;

	cd_state_t st;
	cd_state_t next_st;

	always_comb
	begin
		next_st = st;
		if (i_load)
		begin
			next_st.cnt   = i_value;
			next_st.armed = (i_value != 16'h0000);
		end
		else if (i_tick && st.armed && (st.cnt != 16'h0000))
		begin
			next_st.cnt = st.cnt - 16'h0001;
		end
	end

	always_ff @(posedge i_sys_clk or negedge i_resetn)
	begin
		if (!i_resetn)
			st <= '0;
		else
			st <= next_st;
	end

	assign o_running = st.armed && (st.cnt != 16'h0000);
	assign o_expired = st.armed && (st.cnt == 16'h0000);

endmodule : ms_countdown

// *** rs485_gateway_config_watchdog_bench.sv ***
`timescale 1ns/100ps
module rs485_gateway_config_watchdog_bench;
	import gw_cfg_pkg::*;
	`include "gw_cfg_expect.svh"
	localparam logic [15:0] VER = 16'h0A01; // Arbitrary value
	localparam logic [7:0] DA [11] = '{REG_SPEED, REG_WORD_FMT, REG_PARITY, REG_FRAMING, REG_WATCHDOG,
		REG_OP_MODE, REG_RATE_SLOW, REG_RATE_NORM, REG_RATE_FAST, REG_VERSION, 8'h05};
	localparam logic [15:0] DE [11] = '{16'h0003, 16'h0801, 16'h0000, 16'h0000, 16'h0000, 16'h0001,
		16'h2710, 16'h07D0, 16'h01F4, VER, 16'h0000};
	logic i_sys_clk, i_resetn, i_reg_wr, i_reg_rd, o_reg_ack, i_frm_valid, o_frm_ready, i_frm_first;
	logic i_frm_last, o_ser_valid, i_ser_ready, o_ser_last, i_ser_sent, i_msg_valid, o_nv_store;
	logic i_defaults_restore_switch, o_two_stop_bits, o_seven_data_bits, o_ascii_mode, o_gateway_mode;
	logic o_power_led, o_comm_led, stall;
	logic [7:0] i_reg_addr, i_frm_data, o_ser_data, i_nv_slave_addr, o_slave_addr;
	logic [15:0] i_reg_wdata, o_reg_rdata, o_resp_timeout_ms, o_rate_slow_ms, o_rate_norm_ms, o_rate_fast_ms;
	logic [15:0] rd, c;
	logic [3:0] i_dig_in, o_input_led;
	logic [2:0] o_parity_mode, o_relay, o_relay_led;
	logic [19:0] o_baud_rate;
	logic [31:0] seed;
	logic [7:0] fb [64];
	int err_count, cmp_count, taken, nv_seen, w;

	gw_config_watchdog #(.TICK_CYCLES(10), .VERSION_ID(VER)) i_gw_config_watchdog
	(
		.i_sys_clk, .i_resetn, .i_reg_wr, .i_reg_rd, .i_reg_addr, .i_reg_wdata, .o_reg_ack, .o_reg_rdata,
		.i_frm_valid, .o_frm_ready, .i_frm_data, .i_frm_first, .i_frm_last, .o_ser_valid, .i_ser_ready,
		.o_ser_data, .o_ser_last, .i_ser_sent, .i_msg_valid, .i_defaults_restore_switch, .i_dig_in,
		.i_nv_slave_addr, .o_nv_store, .o_slave_addr, .o_baud_rate, .o_parity_mode, .o_two_stop_bits,
		.o_seven_data_bits, .o_ascii_mode, .o_gateway_mode, .o_resp_timeout_ms, .o_rate_slow_ms,
		.o_rate_norm_ms, .o_rate_fast_ms, .o_relay, .o_relay_led, .o_input_led, .o_power_led, .o_comm_led
	);
	serial_sink i_serial_sink
	(
		.i_sys_clk, .i_resetn, .i_stall(stall), .i_valid(o_ser_valid), .i_data(o_ser_data),
		.i_last(o_ser_last), .o_ready(i_ser_ready), .o_sent(i_ser_sent)
	);

	initial
	begin
		i_sys_clk = 1'b0;
		forever #12.5 i_sys_clk = !i_sys_clk;
	end
	always @(posedge i_sys_clk)
	begin
		if (o_nv_store === 1'b1)
			nv_seen++;
	end
	////////////////////////////////////////
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : rnd
	task automatic results();
		$display("comparisons %0d mismatches %0d", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : results
	task automatic chk(input logic [19:0] got, input logic [19:0] exp);
		cmp_count++;
		if (got !== exp)
		begin
			err_count++;
			$display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task automatic timeout();
		err_count++;
		$display("CHECK FAILED t=%0t wait limit reached", $time);
		results();
	endtask : timeout
	task automatic tick(input int n);
		repeat (n) @(negedge i_sys_clk);
	endtask : tick
	task automatic reg_op(input logic wr, input logic [7:0] a, input logic [15:0] d);
		i_reg_wr = wr;
		i_reg_rd = !wr;
		i_reg_addr = a;
		i_reg_wdata = d;
		tick(1);
		rd = o_reg_rdata;
		chk(20'(o_reg_ack), 20'h1);
		i_reg_wr = 1'b0;
		i_reg_rd = 1'b0;
		tick(1);
	endtask : reg_op
	task automatic rchk(input logic [7:0] a, input logic [15:0] e);
		reg_op(1'b0, a, 16'h0000);
		chk(20'(rd), 20'(e));
	endtask : rchk
	task automatic do_reset(input logic sw);
		i_defaults_restore_switch = sw;
		i_resetn = 1'b0;
		tick(12);
		i_resetn = 1'b1;
		tick(6);
	endtask : do_reset
	task automatic send_frame(input int n);
		int k;
		taken = 0;
		for (k = 0; k < n; k++)
		begin
			i_frm_valid = 1'b1;
			i_frm_data = fb[k];
			i_frm_first = (k == 0);
			i_frm_last = (k == n - 1);
			w = 0;
			do
			begin
				@(posedge i_sys_clk);
				w++;
			end while (!o_frm_ready && w < 400);
			if (w >= 400)
				timeout();
			taken++;
			tick(1);
		end
		i_frm_valid = 1'b0;
	endtask : send_frame
	task automatic got_chk(input int n);
		for (w = 0; i_serial_sink.got.size() < n; w++)
		begin
			if (w == 2000)
				timeout();
			tick(1);
		end
		for (int k = 0; k < n; k++)
			chk(20'(i_serial_sink.got[k]), 20'(fb[k]));
	endtask : got_chk
	////////////////////////////////////////
	initial
	begin
		{i_resetn, i_reg_wr, i_reg_rd, i_frm_valid, i_frm_first, i_frm_last, i_msg_valid, stall} = '0;
		{i_reg_addr, i_reg_wdata, i_frm_data, i_dig_in} = '0;
		i_defaults_restore_switch = 1'b0;
		i_nv_slave_addr = 8'h11;
		seed = 32'h00013911;
		do_reset(1'b0);
		foreach (DA[k])
			rchk(DA[k], DE[k]);
		chk(o_baud_rate, 20'h04B00);
		chk(20'(o_resp_timeout_ms), 20'h001F4);
		chk(20'(o_rate_slow_ms), 20'h02710);
		chk(20'(o_rate_norm_ms), 20'h007D0);
		chk(20'(o_rate_fast_ms), 20'h001F4);
		chk(20'({o_gateway_mode, o_ascii_mode, o_two_stop_bits, o_seven_data_bits}), 20'h8);
		chk(20'(o_slave_addr), 20'h11);
		$display("test defaults done");
		for (int k = 0; k < 12; k++)
		begin
			c = (k < 7) ? 16'(k) : ((k == 11) ? 16'hFFFF : 16'(rnd()));
			reg_op(1'b1, REG_SPEED, c);
			rchk(REG_SPEED, c);
			chk(o_baud_rate, exp_rate(c));
		end
		for (int k = 0; k < 5; k++)
		begin
			reg_op(1'b1, REG_PARITY, 16'(k));
			chk(20'(o_parity_mode), 20'(k));
		end
		for (int k = 0; k < 4; k++)
		begin
			reg_op(1'b1, REG_WORD_FMT, {8'(7 + k[1]), 8'(1 + k[0])});
			chk(20'(o_two_stop_bits), 20'(k[0]));
			chk(20'(o_seven_data_bits), 20'(!k[1]));
			reg_op(1'b1, REG_FRAMING, 16'(k[0]));
			chk(20'(o_ascii_mode), 20'(k[0]));
			i_dig_in = 4'(rnd());
			tick(3);
			chk(20'(o_input_led), 20'(i_dig_in));
			rchk(REG_INPUTS, {12'h000, i_dig_in});
		end
		reg_op(1'b1, REG_SLAVE_ADDR, 16'h0055);
		rchk(REG_SLAVE_ADDR, 16'h0011);
		reg_op(1'b1, REG_OP_MODE, 16'h0000);
		chk(20'(o_gateway_mode), 20'h0);
		$display("test decode done");
		reg_op(1'b1, REG_DFLT_OUT, 16'h0005);
		reg_op(1'b1, REG_OUTPUTS, 16'h0002);
		reg_op(1'b1, REG_WATCHDOG, 16'h0003);
		for (int k = 0; k < 6; k++)
		begin
			i_msg_valid = 1'b1;
			tick(1);
			i_msg_valid = 1'b0;
			tick(19);
		end
		chk(20'(o_relay), 20'h2);
		tick(45);
		chk(20'(o_relay), 20'h5);
		chk(20'(o_relay_led), 20'h5);
		reg_op(1'b1, REG_WATCHDOG, 16'h0000);
		tick(60);
		chk(20'(o_relay), 20'h2);
		$display("test watchdog done");
		fb[0] = 8'h22;
		for (int k = 1; k < 64; k++)
			fb[k] = 8'(rnd());
		send_frame(5);
		got_chk(5);
		tick(2);
		chk(20'(o_comm_led), 20'h1);
		fb[0] = 8'h11;
		send_frame(3);
		tick(10);
		chk(20'(i_serial_sink.got.size()), 20'h5);
		i_serial_sink.got.delete();
		fb[0] = 8'h33;
		stall = 1'b1;
		fork
			send_frame(40);
			begin
				tick(120);
				chk(20'(taken), 20'h20);
				chk(20'(o_frm_ready), 20'h0);
				stall = 1'b0;
			end
		join
		got_chk(40);
		$display("test frames done");
		do_reset(1'b1);
		chk(20'(o_slave_addr), 20'h1);
		chk(20'(nv_seen), 20'h1);
		for (w = 0; o_power_led !== 1'b0; w++)
		begin
			if (w == 3000)
				timeout();
			tick(1);
		end
		chk(20'(o_power_led), 20'h0);
		chk(20'(o_comm_led), 20'h0);
		for (w = 0; o_power_led !== 1'b1; w++)
		begin
			if (w == 3000)
				timeout();
			tick(1);
		end
		chk(20'(o_comm_led), 20'h1);
		i_defaults_restore_switch = 1'b0;
		tick(5);
		rchk(REG_OUTPUTS, 16'h0000);
		rchk(REG_SPEED, 16'h0003);
		$display("test restore done");
		results();
	end
endmodule : rs485_gateway_config_watchdog_bench

// *** serial_sink.sv ***
`timescale 1ns/100ps
module serial_sink
(
	input  wire logic       i_sys_clk,
	input  wire logic       i_resetn,
	input  wire logic       i_stall,
	input  wire logic       i_valid,
	input  wire logic [7:0] i_data,
	input  wire logic       i_last,
	output logic            o_ready,
	output logic            o_sent
);
	logic [7:0] got [$];

	initial
	begin
		o_ready = 1'b0;
		o_sent = 1'b0;
	end

	// Stall holds off pops to let the FIFO fill
	always @(posedge i_sys_clk)
	begin
		o_ready <= i_resetn && !i_stall;
		o_sent <= i_resetn && i_valid && o_ready && i_last;
		if (i_resetn && i_valid && o_ready)
			got.push_back(i_data);
	end
endmodule : serial_sink
